// ---- src/ptc_pkg.sv ----
// Package: terminal control register layout, reset values and tap decode constants
package ptc_pkg;

  // ************************************************************
  // Register layout
  // ************************************************************
  localparam int        TCC_WIDTH        = 8;
  localparam logic [7:0] TCC_RESET       = 8'hff;
  localparam logic [7:0] TCC_RSVD_MASK   = 8'hf0;
  localparam logic [7:0] TCC_WRITE_MASK  = 8'h0f;
  localparam int        BIT_HW_FORCE     = 3;
  localparam int        BIT_TERM_A       = 2;
  localparam int        BIT_WIPER        = 1;
  localparam int        BIT_TERM_B       = 0;

  // ************************************************************
  // Wiper codes
  // ************************************************************
  localparam logic [7:0] WIPER_RESET_8   = 8'h7f;
  localparam logic [7:0] WIPER_RESET_7   = 8'h3f;
  localparam logic [7:0] WIPER_ZERO      = 8'h00;
  localparam logic [7:0] WIPER_FULL_8    = 8'hff;
  localparam logic [7:0] WIPER_FULL_7    = 8'h7f;

  // ************************************************************
  // Command tracking
  // ************************************************************
  typedef enum logic [1:0] {
    PTC_IDLE,
    PTC_HELD
  } ptc_wr_state_t;

endpackage

// ---- src/ptc_tap_decode.sv ----
// Tap decoder: wiper code to one-hot tap select with scale flags
`timescale 1ns/10ps
module ptc_tap_decode #(
  parameter int CODE_BITS = 8
) (
  input  wire logic [CODE_BITS-1:0]      i_code,
  output logic      [(1<<CODE_BITS)-1:0] o_tap_sel,
  output logic                           o_zero_scale,
  output logic                           o_full_scale,
  output logic                           o_mid_scale
);
  import ptc_pkg::*;

  localparam int TAPS = 1 << CODE_BITS;
  localparam logic [CODE_BITS-1:0] MID_CODE = CODE_BITS'((TAPS / 2) - 1);

  // ************************************************************
  // One-hot tap, tap 0 at terminal B
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < TAPS; g = g + 1) begin : g_tap
      assign o_tap_sel[g] = (i_code == CODE_BITS'(g));
    end
  endgenerate

  assign o_zero_scale = (i_code == '0);
  assign o_full_scale = (i_code == '1);
  assign o_mid_scale  = (i_code == MID_CODE);

endmodule

// ---- src/ptc_top.sv ----
// Terminal control register, shutdown override and tap decode for one potentiometer
`timescale 1ns/10ps
module ptc_top #(
  parameter int CODE_BITS = 8
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_tcc_wr_stb,
  input  wire logic [7:0]                     i_tcc_wr_data,
  input  wire logic                           i_cmd_done,
  input  wire logic                           i_wiper_wr_stb,
  input  wire logic [CODE_BITS-1:0]           i_wiper_wr_data,
  input  wire logic                           i_shutdown_pin_n,
  output logic      [7:0]                     o_tcc_rd_data,
  output logic      [CODE_BITS-1:0]           o_wiper_rd_data,
  output logic                                o_term_a_pin_sw,
  output logic                                o_wiper_pin_sw,
  output logic                                o_term_b_pin_sw,
  output logic      [(1<<CODE_BITS)-1:0]      o_tap_sel,
  output logic                                o_zero_scale,
  output logic                                o_full_scale,
  output logic                                o_mid_scale
);
  import ptc_pkg::*;

  localparam logic [CODE_BITS-1:0] WIPER_RST = CODE_BITS'((1 << (CODE_BITS - 1)) - 1);

  // ************************************************************
  // Shutdown pin synchroniser
  // ************************************************************
  logic shutdown_pin_meta_q;
  logic shutdown_pin_sync_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      shutdown_pin_meta_q <= 1'b1;
      shutdown_pin_sync_q <= 1'b1;
    end else begin
      shutdown_pin_meta_q <= i_shutdown_pin_n;
      shutdown_pin_sync_q <= shutdown_pin_meta_q;
    end
  end

  wire shutdown_active = !shutdown_pin_sync_q;

  // ************************************************************
  // Deferred apply of written terminal control values
  // ************************************************************
  logic       apply;
  logic [7:0] apply_data;

  ptc_write_track u_track (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_wr_stb     (i_tcc_wr_stb),
    .i_wr_data    (i_tcc_wr_data),
    .i_cmd_done   (i_cmd_done),
    .o_apply      (apply),
    .o_apply_data (apply_data)
  );

  // ************************************************************
  // Terminal control register
  // ************************************************************
  logic [3:0] tcc_q;
  wire  [3:0] tcc_d = apply ? apply_data[3:0] : tcc_q;

  // Pin never writes here, so release restores the old setup
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tcc_q <= TCC_RESET[3:0];
    end else begin
      tcc_q <= tcc_d;
    end
  end

  assign o_tcc_rd_data = TCC_RSVD_MASK | {4'h0, tcc_q};

  // ************************************************************
  // Wiper register, separate from terminal control
  // ************************************************************
  logic [CODE_BITS-1:0] wiper_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wiper_q <= WIPER_RST;
    end else if (i_wiper_wr_stb) begin
      wiper_q <= i_wiper_wr_data;
    end
  end

  assign o_wiper_rd_data = wiper_q;

  // ************************************************************
  // Switch control
  // ************************************************************
  // Shutdown opens all three terminals; the ladder is left intact
  wire force_open = !tcc_q[BIT_HW_FORCE] || shutdown_active;
  wire sw_a_d     = tcc_q[BIT_TERM_A] && !force_open;
  wire sw_w_d     = tcc_q[BIT_WIPER]  && !force_open;
  wire sw_b_d     = tcc_q[BIT_TERM_B] && !force_open;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_term_a_pin_sw <= 1'b1;
      o_wiper_pin_sw  <= 1'b1;
      o_term_b_pin_sw <= 1'b1;
    end else begin
      o_term_a_pin_sw <= sw_a_d;
      o_wiper_pin_sw  <= sw_w_d;
      o_term_b_pin_sw <= sw_b_d;
    end
  end

  // ************************************************************
  // Tap decode
  // ************************************************************
  ptc_tap_decode #(
    .CODE_BITS (CODE_BITS)
  ) u_tap (
    .i_code       (wiper_q),
    .o_tap_sel    (o_tap_sel),
    .o_zero_scale (o_zero_scale),
    .o_full_scale (o_full_scale),
    .o_mid_scale  (o_mid_scale)
  );

endmodule

// ---- src/ptc_write_track.sv ----
// Write tracker: holds a pending value until its command completes
`timescale 1ns/10ps
module ptc_write_track (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_wr_stb,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_cmd_done,
  output logic            o_apply,
  output logic      [7:0] o_apply_data
);
  import ptc_pkg::*;

  ptc_wr_state_t state_q;
  ptc_wr_state_t state_d;
  logic [7:0]    pend_q;
  logic [7:0]    pend_d;
  logic          apply_q;

  // ************************************************************
  // Pending write, released on command end
  // ************************************************************
  always_comb begin
    state_d = state_q;
    pend_d  = pend_q;
    case (state_q)
      PTC_IDLE: begin
        if (i_wr_stb) begin
          state_d = PTC_HELD;
          pend_d  = i_wr_data;
        end
      end
      PTC_HELD: begin
        if (i_wr_stb) begin
          pend_d = i_wr_data;
        end
        if (i_cmd_done) begin
          state_d = PTC_IDLE;
        end
      end
      default: state_d = PTC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= PTC_IDLE;
      pend_q  <= TCC_RESET;
      apply_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q  <= pend_d;
      apply_q <= (state_q == PTC_HELD) && i_cmd_done;
    end
  end

  assign o_apply      = apply_q;
  assign o_apply_data = pend_q;

endmodule

// ---- test/pot_terminal_control_tap_decode_test.sv ----
// Self-checking bench for the terminal control block
`timescale 1ns/10ps
module pot_terminal_control_tap_decode_test;
  import ptc_pkg::*;
  logic         clk, rst_n, pin_n, stb, done, wstb, a_sw, w_sw, b_sw, zs, fs, ms;
  logic [7:0]   wd, wwd, rd, wrd, cw;
  logic [255:0] tap;
  logic [127:0] tap7;
  logic [6:0]   wrd7;
  logic         zs7, fs7, ms7;
  int           fail_count, checks;
  ptc_top #(.CODE_BITS(8)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_tcc_wr_stb(stb), .i_tcc_wr_data(wd), .i_cmd_done(done),
    .i_wiper_wr_stb(wstb), .i_wiper_wr_data(wwd), .i_shutdown_pin_n(pin_n), .o_tcc_rd_data(rd),
    .o_wiper_rd_data(wrd), .o_term_a_pin_sw(a_sw), .o_wiper_pin_sw(w_sw), .o_term_b_pin_sw(b_sw),
    .o_tap_sel(tap), .o_zero_scale(zs), .o_full_scale(fs), .o_mid_scale(ms));
  ptc_host_model host_u (
    .i_clk(clk), .o_tcc_wr_stb(stb), .o_tcc_wr_data(wd), .o_cmd_done(done), .o_wiper_wr_stb(wstb),
    .o_wiper_wr_data(wwd));
  // Seven-bit copy shares every stimulus, so only the wiper side differs
  ptc_top #(.CODE_BITS(7)) dut7_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_tcc_wr_stb(stb), .i_tcc_wr_data(wd), .i_cmd_done(done),
    .i_wiper_wr_stb(wstb), .i_wiper_wr_data(wwd[6:0]), .i_shutdown_pin_n(pin_n), .o_tcc_rd_data(),
    .o_wiper_rd_data(wrd7), .o_term_a_pin_sw(), .o_wiper_pin_sw(), .o_term_b_pin_sw(),
    .o_tap_sel(tap7), .o_zero_scale(zs7), .o_full_scale(fs7), .o_mid_scale(ms7));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] exp_sw(input logic [7:0] t, input logic p);
    return {5'h0, {3{t[3] & p}} & t[2:0]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tcc(input logic [7:0] t);
    cmp("tcc", {4'hf, t[3:0]}, rd);
    cmp("switches", exp_sw(t, pin_n), {5'h0, a_sw, w_sw, b_sw});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    cw = 8'($urandom(72));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    tcc(TCC_RESET);
    cmp("wiper", WIPER_RESET_8, wrd);
    cmp("wiper7", WIPER_RESET_7, {1'b0, wrd7});
    host_u.write_tcc(8'h00, 1'b0);
    repeat (4) @(negedge clk);
    tcc(TCC_RESET);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      cw = i == 0 ? 8'h07 : i == 1 ? 8'hf8 : i == 2 ? 8'h0a : 8'($urandom);
      host_u.write_tcc(cw, 1'b1);
      repeat (3) @(negedge clk);
      tcc(cw);
      cmp("wiper", WIPER_RESET_8, wrd);
    end
    $display("write test done");
    host_u.write_tcc(8'h0f, 1'b1);
    repeat (3) @(negedge clk);
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    tcc(8'h0f);
    pin_n = 1'b1;
    repeat (4) @(negedge clk);
    tcc(8'h0f);
    $display("shutdown test done");
    for (int i = 0; i < 12; i++) begin
      cw = i == 0 ? WIPER_ZERO : i == 1 ? WIPER_RESET_8 : i == 2 ? WIPER_FULL_8 :
           i == 3 ? WIPER_RESET_7 : 8'($urandom);
      host_u.write_wiper(cw);
      cmp("wiper", cw, wrd);
      cmp("flags", {5'h0, cw == 8'h00, cw == 8'hff, cw == 8'h7f}, {5'h0, zs, fs, ms});
      cmp("tap", 8'h01, {7'h0, tap[cw]});
      cmp("tap count", 8'h01, 8'($countones(tap)));
      cmp("wiper7", {1'b0, cw[6:0]}, {1'b0, wrd7});
      cmp("flags7", {5'h0, cw[6:0] == 7'h00, cw[6:0] == 7'h7f, cw[6:0] == 7'h3f}, {5'h0, zs7, fs7, ms7});
      cmp("tap7", 8'h01, {7'h0, tap7[cw[6:0]]});
      cmp("tap7 count", 8'h01, 8'($countones(tap7)));
    end
    $display("wiper test done");
    host_u.write_tcc(8'h00, 1'b1);
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    tcc(TCC_RESET);
    cmp("wiper", WIPER_RESET_8, wrd);
    cmp("wiper7", WIPER_RESET_7, {1'b0, wrd7});
    host_u.write_tcc(8'h0d, 1'b1);
    repeat (3) @(negedge clk);
    tcc(8'h0d);
    $display("rewrite test done");
    stop_test();
  end
endmodule

// ---- test/ptc_checker.sv ----
// Checker for terminal control register and switch ports
`timescale 1ns/10ps
module ptc_checker (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_cmd_done,
  input wire logic       i_shutdown_pin_n,
  input wire logic [7:0] o_tcc_rd_data,
  input wire logic       o_term_a_pin_sw,
  input wire logic       o_wiper_pin_sw,
  input wire logic       o_term_b_pin_sw
);
  // Reset history keeps $past from reaching into a reset
  logic [3:0] up_q;
  wire        ok = &up_q;
  wire  [7:0] t = o_tcc_rd_data;
  wire        a_en = t[3] & t[2];
  wire        w_en = t[3] & t[1];
  wire        b_en = t[3] & t[0];
  wire        any = o_term_a_pin_sw | o_wiper_pin_sw | o_term_b_pin_sw;
  wire        all = o_term_a_pin_sw & o_wiper_pin_sw & o_term_b_pin_sw;
  always_ff @(posedge i_clk) up_q <= {up_q[2:0], i_reset_n};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_reset_load: assert property (disable iff (1'b0) !i_reset_n |=> t == 8'hff) else $error("tcc reset");
  a_reset_sw: assert property (disable iff (1'b0) !i_reset_n |=> ##1 all) else $error("reset switches");
  a_rsvd_ones: assert property (t[7:4] == 4'hf) else $error("tcc reserved");
  a_apply_done: assert property (ok && $changed(t) |-> $past(i_cmd_done, 2)) else $error("tcc early");
  a_term_a_sw: assert property (ok |-> o_term_a_pin_sw == ($past(a_en) & $past(i_shutdown_pin_n, 3)))
    else $error("term a switch");
  a_wiper_sw: assert property (ok |-> o_wiper_pin_sw == ($past(w_en) & $past(i_shutdown_pin_n, 3)))
    else $error("wiper switch");
  a_term_b_sw: assert property (ok |-> o_term_b_pin_sw == ($past(b_en) & $past(i_shutdown_pin_n, 3)))
    else $error("term b switch");
  a_pin_opens: assert property ((!i_shutdown_pin_n)[*3] |=> !any) else $error("pin override");
  c_apply: cover property (ok && $changed(t));
  c_pin: cover property ($fell(i_shutdown_pin_n));
  c_force: cover property (ok && !t[3]);
endmodule

bind ptc_top ptc_checker chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_done(i_cmd_done), .i_shutdown_pin_n(i_shutdown_pin_n),
  .o_tcc_rd_data(o_tcc_rd_data), .o_term_a_pin_sw(o_term_a_pin_sw), .o_wiper_pin_sw(o_wiper_pin_sw),
  .o_term_b_pin_sw(o_term_b_pin_sw));

// ---- test/ptc_host_model.sv ----
// Host model issuing terminal-control and wiper writes
`timescale 1ns/10ps
module ptc_host_model (
  input  wire logic i_clk,
  output logic       o_tcc_wr_stb,
  output logic [7:0] o_tcc_wr_data,
  output logic       o_cmd_done,
  output logic       o_wiper_wr_stb,
  output logic [7:0] o_wiper_wr_data
);
  initial begin
    o_tcc_wr_stb = 1'b0;
    o_tcc_wr_data = 8'h5a;
    o_cmd_done = 1'b0;
    o_wiper_wr_stb = 1'b0;
    o_wiper_wr_data = 8'ha5;
  end
  // Also the rewrite after a device reset
  // Released data is inverted so a stale byte never looks fresh
  task automatic write_tcc(input logic [7:0] d, input logic fin);
    @(negedge i_clk);
    o_tcc_wr_stb = 1'b1;
    o_tcc_wr_data = d;
    @(negedge i_clk);
    o_tcc_wr_stb = 1'b0;
    o_tcc_wr_data = ~d;
    o_cmd_done = fin;
    @(negedge i_clk);
    o_cmd_done = 1'b0;
  endtask
  task automatic write_wiper(input logic [7:0] d);
    @(negedge i_clk);
    o_wiper_wr_stb = 1'b1;
    o_wiper_wr_data = d;
    @(negedge i_clk);
    o_wiper_wr_stb = 1'b0;
    o_wiper_wr_data = ~d;
  endtask
endmodule
